// *** hw/bpf_defines.svh ***
// Register offsets, field positions, reset values and timing counts of the fault manager.
`ifndef BPF_DEFINES_SVH
`define BPF_DEFINES_SVH
// =====================================================================
// Register byte offsets
`define BPF_PROT_EN_OFS 8'h00
`define BPF_AUTO_FET_OFS 8'h04
`define BPF_FAIL_CFG_OFS 8'h08
`define BPF_FAIL_EN_OFS 8'h0C
`define BPF_FAIL_DLY_OFS 8'h10
`define BPF_STATUS_OFS 8'h14
`define BPF_REG_CMD_OFS 8'h18
`define BPF_FAIL_CAUSE_OFS 8'h1C
// =====================================================================
// Reset values
`define BPF_PROT_EN_RST 16'h0000
`define BPF_AUTO_FET_RST 16'h0000
`define BPF_FAIL_EN_RST 8'h00
`define BPF_FAIL_DLY_RST 32'h0000_0000
// Comparator-based protections sit in bits 5:0, firmware ones above.
`define BPF_HW_PROT_MASK 16'h003F
// =====================================================================
// Timing
`define BPF_CLK_HZ 20000000
`define BPF_EVAL_PERIOD_S 1
`define BPF_EVAL_CYCLES (`BPF_EVAL_PERIOD_S * `BPF_CLK_HZ)
`define BPF_FUSE_PULSE_US 100
`define BPF_FUSE_CYCLES ((`BPF_FUSE_PULSE_US * `BPF_CLK_HZ) / 1000000)
`endif

// *** hw/bpf_fault_mgr.sv ***
// Fault manager: protection gating, permanent-failure checks and APB registers.
// =====================================================================
// Behaviour
// - Each primary protection individually enabled
// - Per-protection choice of autonomous FET control
// - Comparator trips immediate, firmware trips per tick
// - Failure action: flag, FETs off, or fuse
// - External fuse drive counts as failure
// - Failure status volatile, cleared by reset
// - Optionally record failure in OTP
// - OTP write waits for safe conditions
// - Optionally enter lowest power state
// - Sleep waits for fuse and OTP
// - Optionally switch off both regulators
// - Host command re-enables regulators
// - Check failures only after programmable persistence delay
// - Warning flag set on first threshold hit
// - Warning may drive host interrupt pin
// - Checks evaluated only once per second
// - Warning cleared only at quiet evaluation
// - After FET-off failure, monitoring ignored
// - Each failure check individually enabled
// - Host block inputs keep FETs off
`timescale 1ns/1ps
`default_nettype none
`include "bpf_defines.svh"
module bpf_fault_mgr #(
  parameter int EVAL_CYCLES = `BPF_EVAL_CYCLES,
  parameter int NCHK = 8
) (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Protection and check conditions.
  input wire logic [15:0] prot_trip_in,
  input wire logic [NCHK-1:0] perm_failure_cond_in,
  // Host FET block pins.
  input wire logic charge_switch_block_input_in,
  input wire logic discharge_switch_block_input_in,
  // Fuse pin as three signals.
  input wire logic fuse_pin_in,
  output logic fuse_pin_out,
  output logic fuse_pin_oe_out,
  // OTP programmer handshake.
  input wire logic otp_safe_in,
  input wire logic otp_done_in,
  output logic otp_write_out,
  // Power and switch outputs.
  output logic charge_switch_out,
  output logic discharge_switch_out,
  output logic aux_regulator_one_out,
  output logic aux_regulator_two_out,
  output logic lowest_power_state_out,
  output logic alert_out
);
  // Fuse pulse counter width covers the documented pulse length.
  localparam int FUSE_CYCLES = (`BPF_FUSE_CYCLES < 1) ? 1 : `BPF_FUSE_CYCLES;

  // =====================================================================
  // Helpers
  // Decodes a byte offset into a match flag.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // =====================================================================
  // State
  logic [15:0] prot_en_r, prot_en_nxt; // Enabled primary protections.
  logic [15:0] auto_fet_r, auto_fet_nxt; // Protections that steer the FETs.
  bpf_pkg::bpf_fail_cfg_t cfg_r, cfg_nxt; // Failure action configuration.
  logic [NCHK-1:0] chk_en_r, chk_en_nxt; // Enabled failure checks.
  logic [31:0] dly_r, dly_nxt; // Four-bit delay per check, in seconds.
  logic [3:0] cnt_r [NCHK]; // Persistence counters.
  logic [3:0] cnt_nxt [NCHK];
  logic [31:0] tick_r, tick_nxt; // One-second divider.
  logic [15:0] fw_trip_r, fw_trip_nxt; // Firmware trips latched per tick.
  logic warn_r, warn_nxt; // Early warning flag.
  logic failed_r, failed_nxt; // Volatile failure flag.
  logic [NCHK:0] cause_r, cause_nxt; // Failure cause, top bit is fuse sense.
  bpf_pkg::bpf_state_t st_r, st_nxt; // Failure sequencer.
  logic [15:0] fcnt_r, fcnt_nxt; // Fuse pulse counter.
  logic otp_rec_r, otp_rec_nxt; // OTP copy written.
  logic aux1_r, aux1_nxt; // Regulator one enable.
  logic aux2_r, aux2_nxt; // Regulator two enable.
  logic csw_r, csw_nxt; // Charge switch drive.
  logic dsw_r, dsw_nxt; // Discharge switch drive.
  logic fuse_r, fuse_nxt; // Fuse drive.
  logic otpw_r, otpw_nxt; // OTP write request.
  logic sleep_r, sleep_nxt; // Lowest power state request.
  logic alert_r, alert_nxt; // Interrupt pin.
  logic [31:0] rd_r, rd_nxt; // Read data.
  logic rdy_r, rdy_nxt; // Bus ready.
  logic err_r, err_nxt; // Bus error.

  // Combinational helpers.
  logic tick; // Evaluation instant.
  logic wr; // Completing write.
  logic mapped; // Address decodes.
  logic [15:0] trips; // Qualified active protections.
  logic fet_trip; // An autonomous protection is active.
  logic fets_held; // Failure holds FETs off.
  logic [NCHK-1:0] fail_now; // Checks whose delay expired.

  // =====================================================================
  // Next-state logic
  // All state is computed here and registered below; a single process
  // keeps the ordering of failure, command and bus effects in one place.
  always_comb begin
    prot_en_nxt = prot_en_r;
    auto_fet_nxt = auto_fet_r;
    cfg_nxt = cfg_r;
    chk_en_nxt = chk_en_r;
    dly_nxt = dly_r;
    cnt_nxt = cnt_r;
    warn_nxt = warn_r;
    failed_nxt = failed_r;
    cause_nxt = cause_r;
    st_nxt = st_r;
    fcnt_nxt = fcnt_r;
    otp_rec_nxt = otp_rec_r;
    aux1_nxt = aux1_r;
    aux2_nxt = aux2_r;
    fuse_nxt = 1'b0;
    otpw_nxt = 1'b0;
    sleep_nxt = sleep_r;
    fail_now = '0;
    tick = (tick_r == 32'(EVAL_CYCLES - 1));
    tick_nxt = tick ? 32'h0000_0000 : tick_r + 32'h0000_0001;
    wr = psel_in & penable_in & rdy_r & pwrite_in;
    mapped = hit(paddr_in, `BPF_PROT_EN_OFS) | hit(paddr_in, `BPF_AUTO_FET_OFS) |
             hit(paddr_in, `BPF_FAIL_CFG_OFS) | hit(paddr_in, `BPF_FAIL_EN_OFS) |
             hit(paddr_in, `BPF_FAIL_DLY_OFS) | hit(paddr_in, `BPF_STATUS_OFS) |
             hit(paddr_in, `BPF_REG_CMD_OFS) | hit(paddr_in, `BPF_FAIL_CAUSE_OFS);

    // Firmware-evaluated protections only refresh at the tick, while the
    // comparator ones act at once.
    fw_trip_nxt = tick ? (prot_trip_in & ~`BPF_HW_PROT_MASK) : fw_trip_r;
    trips = ((prot_trip_in & `BPF_HW_PROT_MASK) | fw_trip_r) & prot_en_r;
    fet_trip = |(trips & auto_fet_r);
    fets_held = failed_r && (cfg_r.action != bpf_pkg::BPF_ACT_FLAG);

    // Failure checks: once the FETs are held off nothing more is monitored.
    if (tick && !fets_held) begin
      for (int i = 0; i < NCHK; i++) begin
        if (chk_en_r[i] && perm_failure_cond_in[i]) begin
          if (cnt_r[i] != 4'hF) begin
            cnt_nxt[i] = cnt_r[i] + 4'h1;
          end
          if (cnt_r[i] >= dly_r[4*i +: 4]) begin
            fail_now[i] = 1'b1;
          end
        end else begin
          cnt_nxt[i] = 4'h0;
        end
      end
      // Warning follows the sampled conditions only at evaluations.
      warn_nxt = |(chk_en_r & perm_failure_cond_in);
    end

    // Fuse pin high while not driven by us means another protector fired.
    if (fuse_pin_in && !fuse_r && !failed_r) begin
      cause_nxt[NCHK] = 1'b1;
      failed_nxt = 1'b1;
    end
    if (|fail_now && !failed_r) begin
      cause_nxt[NCHK-1:0] = cause_r[NCHK-1:0] | fail_now;
      failed_nxt = 1'b1;
    end

    // Bus writes to configuration and regulator command.
    if (wr) begin
      if (hit(paddr_in, `BPF_PROT_EN_OFS)) begin
        prot_en_nxt = pwdata_in[15:0];
      end
      if (hit(paddr_in, `BPF_AUTO_FET_OFS)) begin
        auto_fet_nxt = pwdata_in[15:0];
      end
      if (hit(paddr_in, `BPF_FAIL_CFG_OFS)) begin
        cfg_nxt = bpf_pkg::bpf_fail_cfg_t'(pwdata_in[5:0]);
      end
      if (hit(paddr_in, `BPF_FAIL_EN_OFS)) begin
        chk_en_nxt = pwdata_in[NCHK-1:0];
      end
      if (hit(paddr_in, `BPF_FAIL_DLY_OFS)) begin
        dly_nxt = pwdata_in;
      end
      if (hit(paddr_in, `BPF_REG_CMD_OFS)) begin
        aux1_nxt = pwdata_in[0];
        aux2_nxt = pwdata_in[1];
      end
    end

    // Failure sequencer: fuse, then OTP copy, then sleep.
    unique case (st_r)
      bpf_pkg::BPF_RUN: begin
        if (failed_r) begin
          if (cfg_r.reg_off_en) begin
            aux1_nxt = 1'b0;
            aux2_nxt = 1'b0;
          end
          if (cfg_r.action == bpf_pkg::BPF_ACT_FUSE) begin
            st_nxt = bpf_pkg::BPF_FUSE;
            fcnt_nxt = 16'h0000;
          end else begin
            st_nxt = bpf_pkg::BPF_OTP_WAIT;
          end
        end
      end
      bpf_pkg::BPF_FUSE: begin
        fuse_nxt = 1'b1;
        fcnt_nxt = fcnt_r + 16'h0001;
        if (fcnt_r == 16'(FUSE_CYCLES)) begin // Full count keeps the drive up FUSE_CYCLES cycles.
          fuse_nxt = 1'b0;
          st_nxt = bpf_pkg::BPF_OTP_WAIT;
        end
      end
      bpf_pkg::BPF_OTP_WAIT: begin
        if (!cfg_r.otp_en) begin
          st_nxt = bpf_pkg::BPF_SETTLE;
        end else if (otp_safe_in) begin
          otpw_nxt = 1'b1;
          st_nxt = bpf_pkg::BPF_OTP_BUSY;
        end
      end
      bpf_pkg::BPF_OTP_BUSY: begin
        otpw_nxt = 1'b1;
        if (otp_done_in) begin
          otpw_nxt = 1'b0;
          otp_rec_nxt = 1'b1;
          st_nxt = bpf_pkg::BPF_SETTLE;
        end
      end
      bpf_pkg::BPF_SETTLE: begin
        // Fuse and OTP are finished by the time this state is reached.
        sleep_nxt = cfg_r.sleep_en;
        st_nxt = bpf_pkg::BPF_HALT;
      end
      bpf_pkg::BPF_HALT: begin
        st_nxt = bpf_pkg::BPF_HALT;
      end
    endcase

    // Switches: host block pins and failure hold always win.
    csw_nxt = !charge_switch_block_input_in && !fet_trip && !fets_held;
    dsw_nxt = !discharge_switch_block_input_in && !fet_trip && !fets_held;
    alert_nxt = warn_r & cfg_r.warn_irq_en;

    // Bus answer: ready on the second access cycle.
    rdy_nxt = psel_in & penable_in & !rdy_r;
    err_nxt = psel_in & penable_in & !rdy_r & !mapped;
    rd_nxt = 32'h0000_0000;
    if (psel_in && !pwrite_in) begin
      if (hit(paddr_in, `BPF_PROT_EN_OFS)) begin
        rd_nxt = {16'h0000, prot_en_r};
      end
      if (hit(paddr_in, `BPF_AUTO_FET_OFS)) begin
        rd_nxt = {16'h0000, auto_fet_r};
      end
      if (hit(paddr_in, `BPF_FAIL_CFG_OFS)) begin
        rd_nxt = {26'h0, cfg_r};
      end
      if (hit(paddr_in, `BPF_FAIL_EN_OFS)) begin
        rd_nxt[NCHK-1:0] = chk_en_r;
      end
      if (hit(paddr_in, `BPF_FAIL_DLY_OFS)) begin
        rd_nxt = dly_r;
      end
      if (hit(paddr_in, `BPF_STATUS_OFS)) begin
        rd_nxt = {16'h0000, 5'h00, otp_rec_r, sleep_r, fuse_r,
                  aux2_r, aux1_r, dsw_r, csw_r, fet_trip, 1'b0, failed_r, warn_r};
      end
      if (hit(paddr_in, `BPF_REG_CMD_OFS)) begin
        rd_nxt = {30'h0, aux2_r, aux1_r};
      end
      if (hit(paddr_in, `BPF_FAIL_CAUSE_OFS)) begin
        rd_nxt[NCHK:0] = cause_r;
      end
    end
  end

  // =====================================================================
  // Registers
  // Synchronous reset; failure state is volatile and cleared here.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      prot_en_r <= `BPF_PROT_EN_RST;
      auto_fet_r <= `BPF_AUTO_FET_RST;
      cfg_r <= '0;
      chk_en_r <= `BPF_FAIL_EN_RST;
      dly_r <= `BPF_FAIL_DLY_RST;
      for (int i = 0; i < NCHK; i++) begin
        cnt_r[i] <= 4'h0;
      end
      tick_r <= 32'h0000_0000;
      fw_trip_r <= 16'h0000;
      warn_r <= 1'b0;
      failed_r <= 1'b0;
      cause_r <= '0;
      st_r <= bpf_pkg::BPF_RUN;
      fcnt_r <= 16'h0000;
      otp_rec_r <= 1'b0;
      aux1_r <= 1'b0;
      aux2_r <= 1'b0;
      csw_r <= 1'b0;
      dsw_r <= 1'b0;
      fuse_r <= 1'b0;
      otpw_r <= 1'b0;
      sleep_r <= 1'b0;
      alert_r <= 1'b0;
      rd_r <= 32'h0000_0000;
      rdy_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      prot_en_r <= prot_en_nxt;
      auto_fet_r <= auto_fet_nxt;
      cfg_r <= cfg_nxt;
      chk_en_r <= chk_en_nxt;
      dly_r <= dly_nxt;
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
      fw_trip_r <= fw_trip_nxt;
      warn_r <= warn_nxt;
      failed_r <= failed_nxt;
      cause_r <= cause_nxt;
      st_r <= st_nxt;
      fcnt_r <= fcnt_nxt;
      otp_rec_r <= otp_rec_nxt;
      aux1_r <= aux1_nxt;
      aux2_r <= aux2_nxt;
      csw_r <= csw_nxt;
      dsw_r <= dsw_nxt;
      fuse_r <= fuse_nxt;
      otpw_r <= otpw_nxt;
      sleep_r <= sleep_nxt;
      alert_r <= alert_nxt;
      rd_r <= rd_nxt;
      rdy_r <= rdy_nxt;
      err_r <= err_nxt;
    end
  end

  // =====================================================================
  // Outputs, each straight from a flip-flop.
  assign prdata_out = rd_r;
  assign pready_out = rdy_r;
  assign pslverr_out = err_r;
  assign fuse_pin_out = fuse_r;
  assign fuse_pin_oe_out = fuse_r;
  assign otp_write_out = otpw_r;
  assign charge_switch_out = csw_r;
  assign discharge_switch_out = dsw_r;
  assign aux_regulator_one_out = aux1_r;
  assign aux_regulator_two_out = aux2_r;
  assign lowest_power_state_out = sleep_r;
  assign alert_out = alert_r;
endmodule
`default_nettype wire

// *** hw/bpf_pkg.sv ***
// Types shared by the battery fault manager.
package bpf_pkg;
  // Action taken on a permanent failure.
  typedef enum logic [1:0] {
    BPF_ACT_FLAG,
    BPF_ACT_FET_OFF,
    BPF_ACT_FUSE
  } bpf_action_t;
  // Permanent-failure configuration word.
  typedef struct packed {
    logic warn_irq_en;
    logic reg_off_en;
    logic sleep_en;
    logic otp_en;
    bpf_action_t action;
  } bpf_fail_cfg_t;
  // Permanent-failure sequencer states.
  typedef enum logic [2:0] {
    BPF_RUN,
    BPF_FUSE,
    BPF_OTP_WAIT,
    BPF_OTP_BUSY,
    BPF_SETTLE,
    BPF_HALT
  } bpf_state_t;
endpackage

// *** tb/bpf_fault_checker.sv ***
// Port-level assertions for the fault manager.
`timescale 1ns/1ps
`default_nettype none
`include "bpf_defines.svh"
module bpf_fault_checker (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_in,
  // Watched ports.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic charge_switch_block_input_in,
  input wire logic discharge_switch_block_input_in,
  input wire logic fuse_pin_out,
  input wire logic fuse_pin_oe_out,
  input wire logic otp_safe_in,
  input wire logic otp_done_in,
  input wire logic otp_write_out,
  input wire logic charge_switch_out,
  input wire logic discharge_switch_out,
  input wire logic lowest_power_state_out
);
  localparam int FUSE_N = `BPF_FUSE_CYCLES; // Length of one fuse pulse.
  logic [15:0] fuse_cnt_r, fuse_cnt_nxt; // Cycles the fuse drive has stood high.
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // =====================================================================
  // Fuse pulse length counter
  always_comb begin
    fuse_cnt_nxt = fuse_pin_out ? fuse_cnt_r + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      fuse_cnt_r <= 16'h0000;
    end else begin
      fuse_cnt_r <= fuse_cnt_nxt;
    end
  end
  // =====================================================================
  // Bus access shape: one wait state, then a single ready pulse.
  sequence setup_s;
    psel_in && !penable_in;
  endsequence
  sequence access_s;
    psel_in && penable_in;
  endsequence
  apb_wait_a: assert property (setup_s ##1 access_s |-> !pready_out ##1 pready_out)
    else $error("ready not on second access cycle");
  err_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("error flagged without ready");
  fuse_oe_same_a: assert property (fuse_pin_oe_out == fuse_pin_out)
    else $error("fuse drive and enable differ");
  fuse_len_a: assert property ($fell(fuse_pin_out) |-> fuse_cnt_r == FUSE_N[15:0])
    else $error("fuse pulse has wrong length");
  cblock_hold_a: assert property (
    charge_switch_block_input_in |=> !charge_switch_out)
    else $error("charge switch on while blocked");
  dblock_hold_a: assert property (
    discharge_switch_block_input_in |=> !discharge_switch_out)
    else $error("discharge switch on while blocked");
  otp_start_a: assert property ($rose(otp_write_out) |-> $past(otp_safe_in))
    else $error("OTP write started while unsafe");
  otp_hold_a: assert property (otp_write_out && !otp_done_in |=> otp_write_out)
    else $error("OTP write dropped before done");
  sleep_order_a: assert property (
    $rose(lowest_power_state_out) |-> !otp_write_out && !fuse_pin_out)
    else $error("sleep entered during fuse or OTP");
  sleep_stay_a: assert property (lowest_power_state_out |=> lowest_power_state_out)
    else $error("sleep state left without reset");
endmodule
bind bpf_fault_mgr bpf_fault_checker u_chk (.mclk_in(mclk_in), .rst_in(rst_in),
  .psel_in(psel_in), .penable_in(penable_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .charge_switch_block_input_in(charge_switch_block_input_in),
  .discharge_switch_block_input_in(discharge_switch_block_input_in),
  .fuse_pin_out(fuse_pin_out), .fuse_pin_oe_out(fuse_pin_oe_out), .otp_safe_in(otp_safe_in),
  .otp_done_in(otp_done_in), .otp_write_out(otp_write_out),
  .charge_switch_out(charge_switch_out), .discharge_switch_out(discharge_switch_out),
  .lowest_power_state_out(lowest_power_state_out));
`default_nettype wire

// *** tb/bpf_fault_mgr_tb_top.sv ***
// Self-checking testbench of the fault manager.
`timescale 1ns/1ps
`default_nettype none
`include "bpf_defines.svh"
module bpf_fault_mgr_tb_top;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwd = 32'h0, prd, rq;
  logic prdy, perr, eq, cblk = 1'b0, dblk = 1'b0, fext = 1'b0, safe = 1'b1;
  logic [15:0] trip = 16'h0;
  logic [7:0] cond = 8'h00;
  logic fo, foe, fwire, odone, owr, csw, dsw, r1, r2, slp, alrt;
  bpf_pkg::bpf_fail_cfg_t cfg; // Permanent-failure configuration being written.
  int miscompares = 0, tests_run = 0;
  // The fuse line has a pull-down: it reads the device's drive, else the external one.
  assign fwire = foe ? fo : fext;
  initial forever #25 clk = ~clk;
  bpf_fault_mgr #(.EVAL_CYCLES(20), .NCHK(8)) uut (.mclk_in(clk), .rst_in(rst),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd),
    .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr), .prot_trip_in(trip),
    .perm_failure_cond_in(cond), .charge_switch_block_input_in(cblk),
    .discharge_switch_block_input_in(dblk), .fuse_pin_in(fwire), .fuse_pin_out(fo),
    .fuse_pin_oe_out(foe), .otp_safe_in(safe), .otp_done_in(odone), .otp_write_out(owr),
    .charge_switch_out(csw), .discharge_switch_out(dsw), .aux_regulator_one_out(r1),
    .aux_regulator_two_out(r2), .lowest_power_state_out(slp), .alert_out(alrt));
  bpf_otp_model #(.LAT(5)) u_otp (.mclk_in(clk), .rst_in(rst), .otp_write_in(owr),
    .otp_done_out(odone));
  // =====================================================================
  // Shared tasks
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Bus transfer: holds the request until ready is sampled high at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 50);
    rq = prd;
    eq = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    // One idle edge keeps a following setup from reassigning psel in this time step.
    @(posedge clk);
    if (n >= 50) begin
      chk("bus ready", 32'h0, 32'h1);
      tally_and_finish();
    end
  endtask
  // Waits for a chosen output to reach a level, cut short by a bound.
  task automatic wait_for(input int s, input logic lvl, input int lim);
    int n;
    n = 0;
    while ((s == 0 ? alrt : s == 1 ? fo : s == 2 ? owr : slp) !== lvl && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      chk("awaited output", 32'h0, 32'h1);
      tally_and_finish();
    end
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    cyc(20);
    chk("sleep in reset", 32'(slp), 32'h0);
    rst <= 1'b0;
    cyc(3);
  endtask
  // =====================================================================
  // Scenarios
  // Enabled comparator trip with auto control cuts the discharge switch; a disabled one leaves charge on.
  task automatic t_primary();
    apb(1'b0, `BPF_PROT_EN_OFS, 32'h0);
    chk("prot_en reset", rq, 32'(`BPF_PROT_EN_RST));
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", 32'(eq), 32'h1);
    chk("unmapped read data", rq, 32'h0);
    apb(1'b1, `BPF_PROT_EN_OFS, 32'h41);
    apb(1'b1, `BPF_AUTO_FET_OFS, 32'h41);
    trip <= 16'h0002;
    cyc(3);
    chk("charge, disabled trip", 32'(csw), 32'h1);
    trip <= 16'h0001;
    cyc(3);
    chk("discharge, auto trip", 32'(dsw), 32'h0);
    // A firmware trip acts at the next evaluation tick, at most one period away.
    trip <= 16'h0040;
    cyc(22);
    chk("charge, firmware trip", 32'(csw), 32'h0);
    trip <= 16'h0000;
    cyc(22);
    chk("charge, firmware trip gone", 32'(csw), 32'h1);
    cblk <= 1'b1;
    cyc(3);
    chk("charge blocked", 32'(csw), 32'h0);
    chk("discharge free", 32'(dsw), 32'h1);
    cblk <= 1'b0;
    cyc(3);
    chk("charge released", 32'(csw), 32'h1);
    $display("test primary done");
  endtask
  // A disabled check never warns; an external fuse drive is taken as a failure.
  task automatic t_fuse_sense();
    cfg = '{warn_irq_en: 1'b1, reg_off_en: 1'b0, sleep_en: 1'b0, otp_en: 1'b0,
            action: bpf_pkg::BPF_ACT_FLAG};
    apb(1'b1, `BPF_FAIL_CFG_OFS, {26'h0, cfg});
    apb(1'b1, `BPF_FAIL_EN_OFS, 32'h1);
    cond <= 8'h02;
    cyc(60);
    apb(1'b0, `BPF_STATUS_OFS, 32'h0);
    chk("warning and failure, disabled check", rq & 32'h3, 32'h0);
    fext <= 1'b1;
    cyc(3);
    apb(1'b0, `BPF_FAIL_CAUSE_OFS, 32'h0);
    chk("fuse cause", rq & 32'h100, 32'h100);
    apb(1'b0, `BPF_STATUS_OFS, 32'h0);
    chk("failure flag", rq & 32'h2, 32'h2);
    chk("charge, flag only", 32'(csw), 32'h1);
    fext <= 1'b0;
    cond <= 8'h00;
    $display("test fuse sense done");
  endtask
  // Full failure: warning, delayed failure, fuse, held OTP write, sleep, regulator command.
  task automatic t_pf();
    apb(1'b1, `BPF_REG_CMD_OFS, 32'h3);
    cfg = '{warn_irq_en: 1'b1, reg_off_en: 1'b1, sleep_en: 1'b1, otp_en: 1'b1,
            action: bpf_pkg::BPF_ACT_FUSE};
    apb(1'b1, `BPF_FAIL_CFG_OFS, {26'h0, cfg});
    apb(1'b1, `BPF_FAIL_EN_OFS, 32'h1);
    apb(1'b1, `BPF_FAIL_DLY_OFS, 32'h1);
    safe <= 1'b0;
    cond <= 8'h01;
    wait_for(0, 1'b1, 60);
    cyc(1);
    chk("fuse before delay", 32'(fo), 32'h0);
    chk("regulator one before failure", 32'(r1), 32'h1);
    wait_for(1, 1'b1, 60);
    cyc(2);
    chk("regs off", {30'h0, r2, r1}, 32'h0);
    chk("charge after failure", 32'(csw), 32'h0);
    wait_for(1, 1'b0, 2100);
    cyc(4);
    chk("otp held while unsafe", 32'(owr), 32'h0);
    chk("no sleep before otp", 32'(slp), 32'h0);
    safe <= 1'b1;
    wait_for(2, 1'b1, 10);
    wait_for(3, 1'b1, 60);
    cond <= 8'h00;
    cyc(3);
    chk("charge stays off", 32'(csw), 32'h0);
    apb(1'b1, `BPF_REG_CMD_OFS, 32'h3);
    cyc(2);
    chk("regs re-enabled", {30'h0, r2, r1}, 32'h3);
    do_reset();
    apb(1'b0, `BPF_STATUS_OFS, 32'h0);
    chk("failure after reset", rq & 32'h2, 32'h0);
    $display("test permanent failure done");
  endtask
  initial begin
    do_reset();
    t_primary();
    t_fuse_sense();
    do_reset();
    t_pf();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// *** tb/bpf_otp_model.sv ***
// Behavioural model of the OTP programmer that answers the fault manager's write requests.
`timescale 1ns/1ps
`default_nettype none
module bpf_otp_model #(
  parameter int LAT = 5
) (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_in,
  // Programming handshake.
  input wire logic otp_write_in,
  output logic otp_done_out
);
  logic [7:0] cnt_r, cnt_nxt; // Cycles spent burning the current word.
  logic done_r, done_nxt; // One-cycle completion pulse.
  // =====================================================================
  // Burn timer
  // A slow burn is modelled so the device must hold its request for several cycles.
  always_comb begin
    cnt_nxt = (otp_write_in && !done_r) ? cnt_r + 8'h01 : 8'h00;
    done_nxt = otp_write_in && !done_r && (cnt_r == LAT[7:0]);
  end
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cnt_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end
  assign otp_done_out = done_r;
endmodule
`default_nettype wire
